// File: hw/sci_pkg.sv
// Purpose: shared constants and types for the serial line control block
// Assumes: classic wishbone slave, 32-bit data, byte registers in low lanes
// Notes:   offsets are word aligned byte addresses
package sci_pkg;

	// ==========================================================
	// register map
	localparam logic [3:0] SCI_OFS_CFG    = 4'h0; // baud divisor, frame options
	localparam logic [3:0] SCI_OFS_CTRL   = 4'h4; // serial_line_control
	localparam logic [3:0] SCI_OFS_STAT   = 4'h8; // serial_status_one
	localparam logic [3:0] SCI_OFS_DATA   = 4'hC; // serial_buffer_reg

	// ==========================================================
	// control bit positions
	localparam int SCI_B_TIE  = 7;
	localparam int SCI_B_TX_DONE_IRQ_EN = 6;
	localparam int SCI_B_RIE  = 5;
	localparam int SCI_B_RX_QUIET_IRQ_EN = 4;
	localparam int SCI_B_TE   = 3;
	localparam int SCI_B_RE   = 2;
	localparam int SCI_B_RWU  = 1;
	localparam int SCI_B_SBK  = 0;

	// configuration bit positions (upper half of cfg word)
	localparam int SCI_B_LOOP = 16;
	localparam int SCI_B_RX_SOURCE_SEL = 17;
	localparam int SCI_B_DIR  = 18;
	localparam int SCI_B_NINE = 19;
	localparam int SCI_B_WAKE = 20;
	localparam int SCI_B_LBRK = 21;

	// ==========================================================
	// reset values and timing
	localparam logic [7:0]  SCI_CTRL_RST = 8'h00;
	localparam logic [15:0] SCI_DIV_RST  = 16'h0010; // clocks per bit
	localparam logic [3:0]  SCI_CHR_8    = 4'hA;     // start+8+stop
	localparam logic [3:0]  SCI_CHR_9    = 4'hB;     // start+9+stop
	localparam logic [3:0]  SCI_LBK_ADD  = 4'h3;     // long break extra bits

	// transmitter job in the shifter
	typedef enum {SCI_TX_IDLE, SCI_TX_DATA, SCI_TX_PRE, SCI_TX_BRK} sci_tx_st_t;

	// status flags
	typedef struct packed {
		logic tx_buf_empty;
		logic tc;
		logic rx_buf_full;
		logic idle;
		logic [3:0] spare;
	} sci_stat_t;

endpackage

// File: hw/sci_tx_rx_control.sv
// Purpose: control register, status flags and simple shifters of a serial port
// Assumes: wishbone classic slave, ack one cycle after request, one clock
// Notes:   pin enables are active low (0 = block drives the pin)
`timescale 1ns/1ps

// Summary of operation
// - empty flag raises irq when enabled
// - done flag raises irq when enabled
// - full flag raises irq when enabled
// - idle flag raises irq when enabled
// - transmitter runs and owns pin while enabled or still busy
// - single-wire direction bit steers shared pin
// - disable then enable mid-frame queues idle
// - pin held until pending characters finish
// - receiver off releases receive pin
// - loopback always releases receive pin
// - standby bit parks receiver awaiting wakeup
// - wakeup by idle line or address mark
// - hardware clears standby on wakeup
// - break request queues break characters repeatedly
// - break length ten/eleven or thirteen/fourteen bits
// - second break may queue before clear
// - control register always readable and writable
// - status register read-only, writes ignored
// - empty flag set on load, cleared by sequence
// - done flag set when nothing sending
// - full flag cleared by status-then-data read
// - loop source picks internal or single-wire
module sci_tx_rx_control
	import sci_pkg::*;
(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// serial pins
	input  wire logic        i_txd,
	output logic             o_txd,
	output logic             o_txd_oe_n,
	input  wire logic        i_rxd,
	output logic             o_rxd_oe_n,
	// interrupt request
	output logic             o_irq
);

	// ==========================================================
	// registers
	// every state bit lives here, each written by exactly one process
	logic [7:0]  ctrl_reg;      // serial_line_control
	logic [15:0] div_reg;       // clocks per bit
	logic [5:0]  opt_reg;       // loop, rx_source_sel, dir, nine, wake, long break
	logic        tx_buf_empty_reg;      // tx_buf_empty
	logic        tc_reg;        // tx_done_flag
	logic        rx_buf_full_reg;      // rx_buf_full
	logic        idle_reg;      // idle line flag
	logic        idle_arm_reg;  // idle may set only after a new character
	logic [8:0]  tbuf_reg;      // transmit buffer
	logic [8:0]  rbuf_reg;      // received character
	logic        stat_rd_reg;   // status read seen, arms clear sequence
	logic        ack_reg;       // bus answer
	logic [31:0] rdat_reg;      // read data
	sci_tx_st_t  tx_st_reg;     // shifter job
	logic [10:0] tsh_reg;       // transmit shift
	logic [3:0]  tbit_reg;      // bits left
	logic [15:0] tcnt_reg;      // tx bit timer
	logic        pre_q_reg;     // queued idle
	logic        brk_q_reg;     // queued break
	logic        te_hold_reg;   // tx keeps pin after disable
	logic        rx_busy_reg;   // receiving a frame
	logic [15:0] rcnt_reg;      // rx bit timer
	logic [3:0]  rbit_reg;      // bits received
	logic [9:0]  rsh_reg;       // receive shift
	logic [3:0]  qcnt_reg;      // idle bit counter
	logic        rx_prev_reg;   // previous rx level

	// ==========================================================
	// decode
	// reads are taken on the first edge of a request, so the read word is
	// registered in time for the ack; writes land on the ack edge itself,
	// the one edge at which the master is sure to still hold its data
	wire        req      = i_wb_cyc & i_wb_stb & ~ack_reg;
	wire        acc      = i_wb_cyc & i_wb_stb & ack_reg;
	wire        wr       = acc & i_wb_we & i_wb_sel[0];
	wire        rd       = req & ~i_wb_we;
	wire        wr_ctrl  = wr & (i_wb_adr == SCI_OFS_CTRL);
	wire        wr_cfg   = wr & (i_wb_adr == SCI_OFS_CFG);
	wire        wr_data  = wr & (i_wb_adr == SCI_OFS_DATA);
	wire        rd_stat  = rd & (i_wb_adr == SCI_OFS_STAT);
	wire        rd_data  = rd & (i_wb_adr == SCI_OFS_DATA);
	wire [7:0]  wctl     = i_wb_dat[7:0];
	wire        te       = ctrl_reg[SCI_B_TE];
	wire        re       = ctrl_reg[SCI_B_RE];
	wire        loop     = opt_reg[SCI_B_LOOP-16];
	wire        rx_source_sel     = opt_reg[SCI_B_RX_SOURCE_SEL-16];
	wire        dir      = opt_reg[SCI_B_DIR-16];
	wire        nine     = opt_reg[SCI_B_NINE-16];
	wire        wake     = opt_reg[SCI_B_WAKE-16];
	wire        lbrk     = opt_reg[SCI_B_LBRK-16];
	// frame length in bit times, start and stop included
	wire [3:0]  chr_bits = nine ? SCI_CHR_9 : SCI_CHR_8;
	wire [3:0]  brk_bits = lbrk ? chr_bits + SCI_LBK_ADD : chr_bits;
	// anything still owed to the line keeps the transmitter alive after
	// tx_on falls: a loaded buffer, a job in the shifter or a queued one
	wire        tx_busy  = (tx_st_reg != SCI_TX_IDLE) | pre_q_reg | brk_q_reg
		| ctrl_reg[SCI_B_SBK] | ~tx_buf_empty_reg;
	wire        tx_run   = te | te_hold_reg;
	wire        tbit_end = (tcnt_reg == div_reg);
	wire        rbit_end = (rcnt_reg == div_reg);
	// rising edge of tx_on with a job in flight queues idle
	wire        te_rise  = wr_ctrl & wctl[SCI_B_TE] & ~te & (tx_st_reg != SCI_TX_IDLE);
	wire        sbk_set  = wr_ctrl & wctl[SCI_B_SBK];

	// receiver input selection
	// internal loop takes our own drive; single-wire receive listens on the pin
	wire        txd_loop;
	wire        single   = loop & rx_source_sel;
	assign txd_loop = (single & ~dir) ? i_txd : o_txd;
	wire        rx_in    = loop ? txd_loop : i_rxd;
	wire        rx_act   = re & ~ctrl_reg[SCI_B_RWU];
	wire        rx_start = re & ~rx_busy_reg & rx_prev_reg & ~rx_in;
	wire        rx_done  = rx_busy_reg & rbit_end & (rbit_reg == chr_bits - 4'h1);
	wire [8:0]  rx_char  = nine ? rsh_reg[9:1] : {1'b0, rsh_reg[9:2]};
	// at the done edge the top data bit sits in bit 9 for both widths,
	// because the stop bit has not been shifted in yet
	wire        rx_msb   = rsh_reg[9];
	wire        line_idl = re & ~rx_busy_reg & (qcnt_reg == chr_bits);
	wire        wake_idl = ~wake & line_idl;
	wire        wake_adr = wake & rx_done & rx_msb;
	wire        wake_hit = ctrl_reg[SCI_B_RWU] & (wake_idl | wake_adr);
	wire        tx_load  = tx_run & (tx_st_reg == SCI_TX_IDLE) & ~tx_buf_empty_reg;
	// done flag: idle level and the software clear; a clear removes its own
	// idle cause (buffer filled, idle or break queued), so it must not lose
	wire        tc_clr   = stat_rd_reg & (wr_data | te_rise | sbk_set);
	wire        tc_idle  = tx_buf_empty_reg & (tx_st_reg == SCI_TX_IDLE) & ~pre_q_reg & ~brk_q_reg
		& ~tx_load & ~tc_clr;

	// ==========================================================
	// control register; standby cleared by hardware on wakeup
	// a software write wins over the wakeup clear in the same cycle, since
	// the write carries the newer intent for every bit of the register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_reg <= SCI_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= wctl;
		end else if (wake_hit) begin
			ctrl_reg[SCI_B_RWU] <= 1'b0;
		end
	end

	// configuration word
	// divisor and options take effect at once; change them only while idle,
	// a frame in flight would otherwise be stretched or cut
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			div_reg <= SCI_DIV_RST;
			opt_reg <= 6'h00;
		end else if (wr_cfg) begin
			div_reg <= i_wb_dat[15:0];
			opt_reg <= i_wb_dat[21:16];
		end
	end

	// ==========================================================
	// bus answer: ack one cycle after the request, dropped next cycle; status writes ignored
	// the read word is captured on the take edge and shown with the ack, so
	// a flag that moves during the wait cycle is reported as it was taken;
	// the status word has no write decode at all, which is what keeps it
	// read-only without a separate guard
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			case (i_wb_adr)
				SCI_OFS_CTRL: rdat_reg <= {24'h00_0000, ctrl_reg};
				SCI_OFS_CFG:  rdat_reg <= {10'h000, opt_reg, div_reg};
				SCI_OFS_STAT: rdat_reg <= {24'h00_0000, tx_buf_empty_reg, tc_reg, rx_buf_full_reg,
					idle_reg, 4'h0};
				SCI_OFS_DATA: rdat_reg <= {23'h0, rbuf_reg};
				default:      rdat_reg <= 32'h0000_0000;
			endcase
		end
	end
	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;

	// ==========================================================
	// status flags and clear sequences
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			tx_buf_empty_reg     <= 1'b1;
			tc_reg       <= 1'b1;
			rx_buf_full_reg     <= 1'b0;
			idle_reg     <= 1'b0;
			idle_arm_reg <= 1'b0;
			stat_rd_reg  <= 1'b0;
			tbuf_reg     <= 9'h000;
			rbuf_reg     <= 9'h000;
		end else begin
			if (rd_stat) begin
				stat_rd_reg <= 1'b1;
			end else if (wr_data | rd_data) begin
				stat_rd_reg <= 1'b0;
			end
			// transmit buffer: load moves it on, set wins over clear
			if (tx_load) begin
				tx_buf_empty_reg <= 1'b1;
			end else if (wr_data & stat_rd_reg) begin
				tx_buf_empty_reg <= 1'b0;
			end
			if (wr_data) begin
				tbuf_reg <= i_wb_dat[8:0];
			end
			// done flag
			if (tc_idle) begin
				tc_reg <= 1'b1;
			end else if (tc_clr) begin
				tc_reg <= 1'b0;
			end
			// receive flags: ignored while in standby
			// a standby receiver still shifts frames, so the address mark of
			// the next message can be seen, but nothing reaches software
			if (rx_done & rx_act) begin
				rx_buf_full_reg     <= 1'b1;
				rbuf_reg     <= rx_char;
				idle_arm_reg <= 1'b1;
			end else if (rd_data & stat_rd_reg) begin
				rx_buf_full_reg <= 1'b0;
			end
			// idle is armed by a received character and fires once per gap,
			// so a line left high for long does not keep raising it
			if (line_idl & idle_arm_reg & rx_act) begin
				idle_reg     <= 1'b1;
				idle_arm_reg <= 1'b0;
			end else if (rd_data & stat_rd_reg) begin
				idle_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// transmitter: queue and shifter
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			tx_st_reg   <= SCI_TX_IDLE;
			tsh_reg     <= 11'h7FF;
			tbit_reg    <= 4'h0;
			tcnt_reg    <= 16'h0000;
			pre_q_reg   <= 1'b0;
			brk_q_reg   <= 1'b0;
			te_hold_reg <= 1'b0;
		end else begin
			if (te_rise) begin
				pre_q_reg <= 1'b1;
			end
			if (sbk_set) begin
				brk_q_reg <= 1'b1;
			end
			// hold follows tx_on one cycle late, then lingers while work is owed;
			// taking it straight from tx_on would drop the pin for one cycle
			te_hold_reg <= te | (te_hold_reg & tx_busy);
			case (tx_st_reg)
				SCI_TX_IDLE: begin
					// priority break, then queued idle, then buffer data; a
					// break request left at one is taken again at every idle
					tcnt_reg <= 16'h0001;
					if (tx_run & (brk_q_reg | ctrl_reg[SCI_B_SBK])) begin
						tx_st_reg <= SCI_TX_BRK;
						brk_q_reg <= 1'b0;
						tsh_reg   <= 11'h000;
						tbit_reg  <= brk_bits;
					end else if (tx_run & pre_q_reg) begin
						tx_st_reg <= SCI_TX_PRE;
						pre_q_reg <= 1'b0;
						tsh_reg   <= 11'h7FF;
						tbit_reg  <= chr_bits;
					end else if (tx_load) begin
						tx_st_reg <= SCI_TX_DATA;
						tsh_reg   <= nine ? {1'b1, tbuf_reg, 1'b0} : {2'b11, tbuf_reg[7:0], 1'b0};
						tbit_reg  <= chr_bits;
					end
				end
				SCI_TX_DATA, SCI_TX_PRE, SCI_TX_BRK: begin
					// one shared bit timer: only data shifts, idle and break
					// just hold their level for the counted bit times
					if (tbit_end) begin
						tcnt_reg <= 16'h0001;
						tsh_reg  <= (tx_st_reg == SCI_TX_DATA) ? {1'b1, tsh_reg[10:1]} : tsh_reg;
						tbit_reg <= tbit_reg - 4'h1;
						if (tbit_reg == 4'h1) begin
							tx_st_reg <= SCI_TX_IDLE;
						end
					end else begin
						tcnt_reg <= tcnt_reg + 16'h0001;
					end
				end
				default: tx_st_reg <= SCI_TX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// receiver: start detect, center sampling, idle count
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rx_busy_reg <= 1'b0;
			rcnt_reg    <= 16'h0000;
			rbit_reg    <= 4'h0;
			rsh_reg     <= 10'h000;
			qcnt_reg    <= 4'h0;
			rx_prev_reg <= 1'b1;
		end else begin
			// previous level starts high, the idle level of the line, so no
			// false start edge follows reset
			rx_prev_reg <= rx_in;
			if (!re) begin
				rx_busy_reg <= 1'b0;
				qcnt_reg    <= 4'h0;
			end else if (rx_start) begin
				rx_busy_reg <= 1'b1;
				rcnt_reg    <= {1'b0, div_reg[15:1]}; // sample mid bit
				rbit_reg    <= 4'h0;
				qcnt_reg    <= 4'h0;
			end else if (rx_busy_reg) begin
				// each sample lands mid bit; the last one is the stop bit
				if (rbit_end) begin
					rcnt_reg <= 16'h0001;
					rsh_reg  <= {rx_in, rsh_reg[9:1]};
					rbit_reg <= rbit_reg + 4'h1;
					if (rx_done) begin
						rx_busy_reg <= 1'b0;
					end
				end else begin
					rcnt_reg <= rcnt_reg + 16'h0001;
				end
			end else if (rx_in & (qcnt_reg != chr_bits)) begin
				// whole bit times of high line count toward idle
				if (rbit_end) begin
					rcnt_reg <= 16'h0001;
					qcnt_reg <= qcnt_reg + 4'h1;
				end else begin
					rcnt_reg <= rcnt_reg + 16'h0001;
				end
			end
		end
	end

	// ==========================================================
	// pins: tx driven while transmitter owns it, unless single-wire input
	// the drive level is one whenever the shifter is idle, so handing the pin
	// over or taking it back never shows a spurious low on the line
	// limitation: the pad's own pull decides the level while released
	assign o_txd      = (tx_st_reg == SCI_TX_IDLE) ? 1'b1 : tsh_reg[0];
	assign o_txd_oe_n = ~(tx_run & ~(single & ~dir));
	// the receive pin is input only: with the receiver off or looped back
	// the pin is simply left to general-purpose use
	assign o_rxd_oe_n = 1'b1;
	assign o_irq = (ctrl_reg[SCI_B_TIE]  & tx_buf_empty_reg)
	             | (ctrl_reg[SCI_B_TX_DONE_IRQ_EN] & tc_reg)
	             | (ctrl_reg[SCI_B_RIE]  & rx_buf_full_reg)
	             | (ctrl_reg[SCI_B_RX_QUIET_IRQ_EN] & idle_reg);

endmodule

// File: dv/sci_remote_node.sv
// Purpose: remote serial node on the far side of the transmit and receive lines
// Assumes: start + 8 data + stop, lsb first, DIV clocks per bit
// Notes:   the line idles at mark level, as a pulled-up wire would
`timescale 1ns/1ps
module sci_remote_node #(
	parameter int DIV = 16 // clocks per bit
) (
	input  wire logic i_clk,  // system clock for timing bits
	input  wire logic i_line, // level of the block's transmit pin
	output logic      o_line  // drives the block's receive pin
);
	// ==========================================
	// sender
	initial o_line = 1'b1;
	// one frame, changed just after an edge so the block never races it
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_line <= f[i];
			repeat (DIV) @(posedge i_clk);
		end
	endtask
	// ==========================================
	// receiver: mid-bit sampling tolerates edge jitter of DIV/2
	task automatic grab(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (i_line !== 1'b0 && n < 4000) begin
			@(posedge i_clk);
			n++;
		end
		repeat (DIV / 2) @(posedge i_clk);
		ok = (i_line === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge i_clk);
			b[i] = i_line;
		end
		repeat (DIV) @(posedge i_clk);
		ok = ok && (i_line === 1'b1) && (n < 4000);
	endtask
endmodule

// File: dv/sci_tx_rx_control_monitor.sv
// Purpose: port-level checks of the serial control block
// Assumes: one clock, sync active low reset, ack one cycle after take
// Notes:   ctrl_reg mirrors what software wrote to the control register
`timescale 1ns/1ps
module sci_tx_rx_control_mon
	import sci_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [3:0]  i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_txd,
	input wire logic        o_txd,
	input wire logic        o_txd_oe_n,
	input wire logic        i_rxd,
	input wire logic        o_rxd_oe_n,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// control mirror, updated at the ack edge like the block itself
	logic [7:0] ctrl_reg;
	wire        ctrl_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0]
		& (i_wb_adr == SCI_OFS_CTRL);
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) ctrl_reg <= SCI_CTRL_RST;
		else if (ctrl_wr) ctrl_reg <= i_wb_dat[7:0];
	end
	// ==========================================
	// assertions
	AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not acked next cycle");
	AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	AST_CTRL_READ: assert property (o_wb_ack && !i_wb_we && i_wb_adr == SCI_OFS_CTRL
		|-> o_wb_dat[7:2] == ctrl_reg[7:2]) else $error("control readback wrong");
	AST_UNMAP_ZERO: assert property (o_wb_ack && !i_wb_we && i_wb_adr[1:0] != 2'h0
		|-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
	AST_IRQ_GATE: assert property (o_irq |-> |ctrl_reg[7:4])
		else $error("irq with all enables clear");
	AST_RX_PIN_FREE: assert property (o_rxd_oe_n)
		else $error("receive pin driven");
	AST_LOW_DRIVEN: assert property (!o_txd |-> !o_txd_oe_n)
		else $error("low level while pin released");
	AST_STAY_OFF: assert property (!ctrl_reg[3] && !ctrl_wr && o_txd_oe_n |=> o_txd_oe_n)
		else $error("pin taken with transmitter off");
endmodule
bind sci_tx_rx_control sci_tx_rx_control_mon mon_u (
	.i_sys_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
	.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_txd, .o_txd, .o_txd_oe_n, .i_rxd,
	.o_rxd_oe_n, .o_irq
);

// File: dv/tb_top.sv
// Purpose: self-checking bench for the serial control block
// Assumes: default 16 clocks per bit, 8-bit frames
// Notes:   the transmit pin is pulled up whenever the block releases it
`timescale 1ns/1ps
module tb_top
	import sci_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack, txd, txd_oe_n, rxd, rxd_oe_n, irq;
	wire         txd_pin = txd_oe_n ? 1'b1 : txd; // pull-up when released
	int          miscompares = 0;
	int          n_compared = 0;
	int          run = 0;
	int          last_low = 0;
	always #2 clk = ~clk;
	sci_tx_rx_control dut_u (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_txd(txd_pin), .o_txd(txd),
		.o_txd_oe_n(txd_oe_n), .i_rxd(rxd), .o_rxd_oe_n(rxd_oe_n), .o_irq(irq));
	sci_remote_node #(.DIV(16)) node_u (.i_clk(clk), .i_line(txd_pin), .o_line(rxd));
	// length of the latest low stretch on the line, for break timing
	always @(posedge clk) begin
		if (txd_pin === 1'b0) run <= run + 1;
		else if (run != 0) begin
			last_low <= run;
			run <= 0;
		end
	end
	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one classic cycle, held until ack is seen at an edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		chk(n, 2, "ack latency");
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		rd(SCI_OFS_CTRL, q);
		chk(q, 32'h0, "ctrl reset");
		wr(SCI_OFS_STAT, 32'h0);
		rd(SCI_OFS_STAT, q);
		chk(q, 32'h0000_00C0, "status after write");
		rd(4'h2, q);
		chk(q, 32'h0, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_irq();
		logic [3:0] e;
		e = 4'b1100;
		for (int i = 0; i < 5; i++) begin
			wr(SCI_OFS_CTRL, 32'h80 >> i);
			chk({31'h0, irq}, {31'h0, i < 4 && e[3 - i]}, "irq gate");
		end
		$display("test irq done");
	endtask
	task automatic t_tx();
		logic [31:0] q;
		logic [7:0]  b;
		logic        ok;
		wr(SCI_OFS_CTRL, 32'h08);
		chk({31'h0, txd_oe_n}, 32'h0, "tx drives pin");
		rd(SCI_OFS_STAT, q);
		wr(SCI_OFS_DATA, 32'hA5);
		rd(SCI_OFS_STAT, q);
		chk(q, 32'h0000_0080, "tx busy flags");
		wr(SCI_OFS_CTRL, 32'h00);
		chk({31'h0, txd_oe_n}, 32'h0, "pin kept");
		node_u.grab(b, ok);
		chk({23'h0, ok, b}, {23'h0, 1'b1, 8'hA5}, "tx frame");
		repeat (40) @(posedge clk);
		chk({31'h0, txd_oe_n}, 32'h1, "pin released");
		rd(SCI_OFS_STAT, q);
		chk(q, 32'h0000_00C0, "tx idle flags");
		$display("test tx done");
	endtask
	task automatic t_brk();
		int e;
		for (int l = 0; l < 2; l++) begin
			e = (10 + 3 * l) * 16;
			wr(SCI_OFS_CFG, {10'h0, l[0], 21'h10});
			wr(SCI_OFS_CTRL, 32'h09);
			wr(SCI_OFS_CTRL, 32'h08);
			repeat (800) @(posedge clk);
			chk(last_low == e || last_low == 2 * e, 1, "break length");
		end
		wr(SCI_OFS_CFG, 32'h10);
		wr(SCI_OFS_CTRL, 32'h00);
		$display("test break done");
	endtask
	task automatic t_rx();
		logic [31:0] q;
		wr(SCI_OFS_CTRL, 32'h24);
		node_u.send(8'h3C);
		repeat (4) @(posedge clk);
		chk({31'h0, irq}, 32'h1, "rx irq");
		rd(SCI_OFS_STAT, q);
		chk({29'h0, q[7:5]}, 32'h7, "rx full");
		rd(SCI_OFS_DATA, q);
		chk({24'h0, q[7:0]}, 32'h3C, "rx data");
		rd(SCI_OFS_STAT, q);
		chk({31'h0, q[5]}, 32'h0, "rx cleared");
		$display("test rx done");
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_irq();
		t_tx();
		t_brk();
		t_rx();
		results();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
endmodule
